// >>> core/ocd_defines.vh
// constants for the opcode decoder front end
// assumes inclusion by bare name from the core design files
`ifndef OCD_DEFINES_VH
`define OCD_DEFINES_VH

`define OCD_LEN_1 2'h1
`define OCD_LEN_2 2'h2
`define OCD_LEN_3 2'h3

// instruction classes
`define OCD_CLS_OTHER 2'h0
`define OCD_CLS_COPY 2'h1
`define OCD_CLS_PUSH 2'h2
`define OCD_CLS_POP 2'h3

// clock-cycle counts of the decoded groups
`define OCD_CYC_COPY 5'h05
`define OCD_CYC_PUSH 5'h0B
`define OCD_CYC_POP 5'h0A

// field positions
`define OCD_DST_HI 5
`define OCD_DST_LO 3
`define OCD_RP_HI 5
`define OCD_RP_LO 4

`define OCD_PC_RST 16'h0000

`endif

// >>> core/ocd_len_table.v
// opcode to instruction length and class lookup
// assumes the raw fetched byte at its input; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "ocd_defines.vh"
module ocd_len_table (
  input wire [7:0] opcode,   // first byte of instruction
  output reg [1:0] ilen,     // bytes in instruction
  output reg [1:0] icls      // decoded group
);
  // length follows the operation; unknown groups default to one byte
  always @* begin
    ilen = `OCD_LEN_1;
    icls = `OCD_CLS_OTHER;
    // memory forms (field 6 on either side) are slower and not plain register copies
    if (opcode[7:6] == 2'h1 && opcode[5:3] != 3'h6 && opcode[2:0] != 3'h6) begin
      icls = `OCD_CLS_COPY;
    end else if (opcode[7:6] == 2'h3 && opcode[3:0] == 4'h5) begin
      icls = `OCD_CLS_PUSH;
    end else if (opcode[7:6] == 2'h3 && opcode[3:0] == 4'h1) begin
      icls = `OCD_CLS_POP;
    end
    // immediate and port instructions carry one operand byte
    if ((opcode[7:6] == 2'h0 && opcode[2:0] == 3'h6) ||
        (opcode[7:6] == 2'h3 && opcode[2:0] == 3'h6) ||
        opcode == 8'hD3 || opcode == 8'hDB) begin
      ilen = `OCD_LEN_2;
    end
    // jumps, calls, pair immediates and direct load/store
    if ((opcode[7:6] == 2'h3 && opcode[2:0] == 3'h2) ||
        (opcode[7:6] == 2'h3 && opcode[2:0] == 3'h4) ||
        opcode == 8'hC3 || opcode == 8'hCD ||
        (opcode[7:6] == 2'h0 && opcode[3:0] == 4'h1) ||
        opcode == 8'h22 || opcode == 8'h2A ||
        opcode == 8'h32 || opcode == 8'h3A) begin
      ilen = `OCD_LEN_3;
    end
  end
endmodule
`default_nettype wire

// >>> core/ocd_field_split.v
// splits a copy or stack opcode into its register fields
// assumes the opcode is stable while the outputs are used
`timescale 1ns/1ps
`default_nettype none
`include "ocd_defines.vh"
module ocd_field_split (
  input wire [7:0] opcode,    // raw fetched byte
  output wire [2:0] dst_sel,  // dest_reg_field
  output wire [2:0] src_sel,  // src_reg_field
  output wire [1:0] pair_sel  // 0 b/c, 1 d/e, 2 h/l, 3 accumulator_and_flags_word
);
  // fields are straight bit slices of the opcode
  assign dst_sel = opcode[`OCD_DST_HI:`OCD_DST_LO];
  assign src_sel = opcode[2:0];
  assign pair_sel = opcode[`OCD_RP_HI:`OCD_RP_LO];
endmodule
`default_nettype wire

// >>> core/ocd_decoder.v
// instruction fetch sequencer and opcode decoder front end
// assumes program memory answers a fetch request with mem_valid later
// What this block does
// - all data handled as 8-bit unsigned bytes
// - instruction length is one, two or three
// - first byte is opcode, selects later layout
// - copy, stack, alu and others are single byte
// - immediate and port instructions take two bytes
// - jump, call, direct load/store take three
// - second byte is low address or operand
// - third byte is high half of word
// - bus uses positive logic, high is one
// - 01dddsss with neither field 6 copies source to destination, 5 cycles
// - 11rp0001 restores pair from stack, 10 cycles
`timescale 1ns/1ps
`default_nettype none
`include "ocd_defines.vh"
module ocd_decoder (
  input wire sys_clk,          // processor clock
  input wire nrst,             // async reset, active low
  input wire [7:0] mem_data,   // byte from program memory
  input wire mem_valid,        // mem_data holds requested byte
  input wire exec_done,        // execution finished, start next fetch
  output wire mem_req,         // fetch request, level
  output reg [15:0] mem_addr,  // fetch address
  output reg [7:0] opcode_r,   // latched opcode
  output reg [1:0] ilen_r,     // instruction length
  output reg [7:0] operand_r,  // second byte
  output reg [15:0] word_r,    // high:low of three-byte form
  output reg [1:0] icls_r,     // decoded group
  output reg [2:0] dst_r,      // dest_reg_field
  output reg [2:0] src_r,      // src_reg_field
  output reg [1:0] pair_r,     // stack pair code
  output reg [4:0] cycles_r,   // clock cycles of decoded group, 0 if unknown
  output reg len_valid_r,      // ilen_r valid
  output reg instr_valid_r     // whole instruction assembled, level
);
  localparam ST_OP = 2'h0;
  localparam ST_B2 = 2'h1;
  localparam ST_B3 = 2'h2;
  localparam ST_EXE = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [15:0] pc_r;
  wire [1:0] tbl_len;
  wire [1:0] tbl_cls;
  wire [2:0] f_dst;
  wire [2:0] f_src;
  wire [1:0] f_pair;
  reg [4:0] cyc_sel;

  // lookup runs on the raw byte so length is ready at the latch edge
  ocd_len_table u_tbl (
    .opcode(mem_data),
    .ilen(tbl_len),
    .icls(tbl_cls)
  );

  ocd_field_split u_split (
    .opcode(mem_data),
    .dst_sel(f_dst),
    .src_sel(f_src),
    .pair_sel(f_pair)
  );

  // cycle count per group
  always @* begin
    case (tbl_cls)
      `OCD_CLS_COPY: cyc_sel = `OCD_CYC_COPY;
      `OCD_CLS_PUSH: cyc_sel = `OCD_CYC_PUSH;
      `OCD_CLS_POP: cyc_sel = `OCD_CYC_POP;
      default: cyc_sel = 5'h00;
    endcase
  end

  // request bytes in every fetch state; bus levels are plain positive logic
  assign mem_req = (state_r != ST_EXE);

  // next state from length; extra bytes only for two- and three-byte forms
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OP: begin
        if (mem_valid) begin
          state_nxt = (tbl_len == `OCD_LEN_1) ? ST_EXE : ST_B2;
        end
      end
      ST_B2: begin
        if (mem_valid) begin
          state_nxt = (ilen_r == `OCD_LEN_3) ? ST_B3 : ST_EXE;
        end
      end
      ST_B3: begin
        if (mem_valid) begin
          state_nxt = ST_EXE;
        end
      end
      ST_EXE: begin
        if (exec_done) begin
          state_nxt = ST_OP;
        end
      end
      default: state_nxt = ST_OP;
    endcase
  end

  // state, program counter and byte capture
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_OP;
      pc_r <= `OCD_PC_RST;
      mem_addr <= `OCD_PC_RST;
      opcode_r <= 8'h00;
      ilen_r <= 2'h0;
      operand_r <= 8'h00;
      word_r <= 16'h0000;
      icls_r <= 2'h0;
      dst_r <= 3'h0;
      src_r <= 3'h0;
      pair_r <= 2'h0;
      cycles_r <= 5'h00;
      len_valid_r <= 1'b0;
      instr_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // each taken byte steps the counter, so bytes come in rising order
      if (mem_valid && state_r != ST_EXE) begin
        pc_r <= pc_r + 16'h0001;
        mem_addr <= pc_r + 16'h0001;
      end
      case (state_r)
        ST_OP: begin
          instr_valid_r <= 1'b0;
          if (mem_valid) begin
            opcode_r <= mem_data;
            ilen_r <= tbl_len;
            len_valid_r <= 1'b1;
            icls_r <= tbl_cls;
            dst_r <= f_dst;
            src_r <= f_src;
            pair_r <= f_pair;
            cycles_r <= cyc_sel;
            operand_r <= 8'h00;
            word_r <= 16'h0000;
            if (tbl_len == `OCD_LEN_1) begin
              instr_valid_r <= 1'b1;
            end
          end
        end
        ST_B2: begin
          if (mem_valid) begin
            operand_r <= mem_data;
            word_r[7:0] <= mem_data;
            if (ilen_r == `OCD_LEN_2) begin
              instr_valid_r <= 1'b1;
            end
          end
        end
        ST_B3: begin
          if (mem_valid) begin
            word_r[15:8] <= mem_data;
            instr_valid_r <= 1'b1;
          end
        end
        ST_EXE: begin
          if (exec_done) begin
            instr_valid_r <= 1'b0;
            len_valid_r <= 1'b0;
          end
        end
        default: begin
          instr_valid_r <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verif/ocd_mem_model.sv
// program memory model on the fetch port
// assumes the bench preloads mem and drives slow
`timescale 1ns/1ps
`default_nettype none
module ocd_mem_model (
  input wire logic clk, // clock
  input wire logic req, // fetch request
  input wire logic [15:0] addr, // fetch address
  input wire logic slow, // wait every other cycle
  output logic [7:0] data, // byte out
  output logic valid // byte ready
);
  logic [7:0] mem [0:63];
  logic tog;
  initial begin
    tog = 1'b0;
    valid = 1'b0;
    data = 8'h5A;
  end
  // answer off the sampling edge; in any cycle without an answer the byte is inverted again, so it alternates
  always @(negedge clk) begin
    tog <= ~tog;
    valid <= req && !(slow && tog);
    data <= (req && !(slow && tog)) ? mem[addr[5:0]] : ~data;
  end
endmodule
`default_nettype wire

// >>> verif/ocd_props.sv
// port checker for the decoder front end
// assumes bind onto ocd_decoder
`timescale 1ns/1ps
`default_nettype none
module ocd_props (
  input wire sys_clk, // clock
  input wire nrst, // reset
  input wire [7:0] mem_data, // byte
  input wire mem_valid, // byte ready
  input wire exec_done, // done
  input wire mem_req, // request
  input wire [15:0] mem_addr, // address
  input wire [7:0] opcode_r, // opcode
  input wire [1:0] ilen_r, // length
  input wire [7:0] operand_r, // operand
  input wire [15:0] word_r, // word
  input wire [2:0] dst_r, // dest
  input wire [2:0] src_r, // source
  input wire [1:0] pair_r, // pair
  input wire [1:0] icls_r, // group
  input wire [4:0] cycles_r, // cycles
  input wire len_valid_r, // length valid
  input wire instr_valid_r // assembled
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // the last byte is taken one edge before the instruction counts as assembled
  sequence s_last_byte;
    mem_req && mem_valid ##1 $rose(instr_valid_r);
  endsequence
  a_addr_step: assert property (mem_req && mem_valid |=> mem_addr == $past(mem_addr) + 16'h0001)
    else $error("fetch address did not step");
  a_opcode_latch: assert property (mem_req && mem_valid && !len_valid_r
    |=> len_valid_r && opcode_r == $past(mem_data))
    else $error("opcode not latched");
  // register copies only: a memory operand on either side is a different group
  a_copy_fields: assert property (len_valid_r && opcode_r[7:6] == 2'h1
    && opcode_r[5:3] != 3'h6 && opcode_r[2:0] != 3'h6
    |-> icls_r == 2'h1 && cycles_r == 5'h05
    && dst_r == opcode_r[5:3] && src_r == opcode_r[2:0])
    else $error("copy decode wrong");
  a_push_pair: assert property (len_valid_r && opcode_r[7:6] == 2'h3 && opcode_r[3:0] == 4'h5
    |-> icls_r == 2'h2 && cycles_r == 5'h0B && pair_r == opcode_r[5:4])
    else $error("save decode wrong");
  a_pop_pair: assert property (len_valid_r && opcode_r[7:6] == 2'h3 && opcode_r[3:0] == 4'h1
    |-> icls_r == 2'h3 && cycles_r == 5'h0A && pair_r == opcode_r[5:4])
    else $error("restore decode wrong");
  a_one_byte: assert property (len_valid_r && ilen_r == 2'h1 |-> instr_valid_r && !mem_req)
    else $error("single byte not complete");
  a_high_byte: assert property (s_last_byte |-> ilen_r != 2'h3 || word_r[15:8] == $past(mem_data))
    else $error("high byte wrong");
  a_operand_byte: assert property (s_last_byte |-> ilen_r != 2'h2 || operand_r == $past(mem_data))
    else $error("operand byte wrong");
  a_exec_clear: assert property (exec_done && instr_valid_r |=> !len_valid_r && mem_req)
    else $error("execute did not return to fetch");
endmodule
bind ocd_decoder ocd_props u_props (.sys_clk, .nrst, .mem_data, .mem_valid, .exec_done, .mem_req,
  .mem_addr, .opcode_r, .ilen_r, .operand_r, .word_r, .dst_r, .src_r, .pair_r, .icls_r, .cycles_r,
  .len_valid_r, .instr_valid_r);
`default_nettype wire

// >>> verif/tb_ocd_decoder.sv
// testbench for the decoder front end
// assumes the memory model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_ocd_decoder;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic exec_done = 1'b0;
  logic slow = 1'b0;
  wire [7:0] mem_data;
  wire mem_valid, mem_req, len_valid_r, instr_valid_r;
  wire [15:0] mem_addr, word_r;
  wire [7:0] operand_r;
  wire [1:0] ilen_r;
  wire [4:0] cycles_r;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // rows: opcode, byte 2, byte 3, length, cycle count
  // the last row is a copy from memory, which is not counted as a register copy
  logic [39:0] rows [0:15] = '{40'h47_00_00_01_05, 40'h78_00_00_01_05, 40'hC5_00_00_01_0B,
    40'hD5_00_00_01_0B, 40'hE5_00_00_01_0B, 40'hF5_00_00_01_0B, 40'hC1_00_00_01_0A,
    40'hD1_00_00_01_0A, 40'hE1_00_00_01_0A, 40'hF1_00_00_01_0A, 40'h3E_A5_00_02_00,
    40'hDB_5A_00_02_00, 40'hC3_34_12_03_00, 40'hCD_FF_80_03_00, 40'h32_01_FE_03_00,
    40'h7E_00_00_01_00};
  ocd_decoder u_ocd_decoder (.sys_clk(sys_clk), .nrst(nrst), .mem_data(mem_data),
    .mem_valid(mem_valid), .exec_done(exec_done), .mem_req(mem_req), .mem_addr(mem_addr),
    .opcode_r(), .ilen_r(ilen_r), .operand_r(operand_r), .word_r(word_r), .icls_r(),
    .dst_r(), .src_r(), .pair_r(), .cycles_r(cycles_r), .len_valid_r(len_valid_r),
    .instr_valid_r(instr_valid_r));
  ocd_mem_model u_ocd_mem_model (.clk(sys_clk), .req(mem_req), .addr(mem_addr), .slow(slow),
    .data(mem_data), .valid(mem_valid));
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, generous against under 100 cycles of traffic
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  task wait_iv;
    repeat (40) if (instr_valid_r !== 1'b1) @(negedge sys_clk);
    chk("assembled", {15'h0000, instr_valid_r}, 16'h0001);
  endtask
  // preload the program, then walk the rows with slow set on the odd ones; the model sees it an edge late, so only rows 2 and 13 get wait cycles
  initial begin
    int i, a;
    logic [39:0] r;
    a = 0;
    for (i = 0; i < 16; i++) begin
      r = rows[i];
      u_ocd_mem_model.mem[a] = r[39:32];
      u_ocd_mem_model.mem[a + 1] = r[31:24];
      u_ocd_mem_model.mem[a + 2] = r[23:16];
      a = a + r[15:8];
    end
    // a full three-byte instruction for the cut fetch, so no unknown byte is taken
    u_ocd_mem_model.mem[a] = 8'hC3;
    u_ocd_mem_model.mem[a + 1] = 8'h34;
    u_ocd_mem_model.mem[a + 2] = 8'h12;
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    a = 0;
    for (i = 0; i < 16; i++) begin
      r = rows[i];
      // the model samples slow on this same edge, so update it after that read
      slow <= i[0];
      wait_iv();
      chk("length", {14'h0000, ilen_r}, {8'h00, r[15:8]});
      chk("cycles", {11'h000, cycles_r}, {8'h00, r[7:0]});
      if (r[15:8] == 8'h03) chk("word", word_r, {r[23:16], r[31:24]});
      else chk("operand", {8'h00, operand_r}, {8'h00, r[15:8] == 8'h02 ? r[31:24] : 8'h00});
      a = a + r[15:8];
      chk("addr", mem_addr, a[15:0]);
      chk("request", {15'h0000, mem_req}, 16'h0000);
      exec_done = 1'b1;
      @(negedge sys_clk);
      exec_done = 1'b0;
      $display("row %0d done", i);
    end
    // done pulse in mid fetch is ignored, then reset cuts the fetch short
    slow <= 1'b0;
    repeat (40) if (len_valid_r !== 1'b1) @(negedge sys_clk);
    exec_done = 1'b1;
    @(negedge sys_clk);
    exec_done = 1'b0;
    chk("fetch kept", {15'h0000, len_valid_r}, 16'h0001);
    nrst = 1'b0;
    #1;
    chk("reset addr", mem_addr, 16'h0000);
    @(negedge sys_clk);
    nrst = 1'b1;
    wait_iv();
    chk("restart", {14'h0000, ilen_r}, 16'h0001);
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
